// *** shared/bor_pkg.sv ***
package bor_pkg;

    // ************************************************************
    // Mode, threshold and timing
    // ************************************************************

    // Brown-out mode field encodings
    typedef enum logic [1:0] {
        BOR_MODE_OFF    = 2'h0,
        BOR_MODE_SW     = 2'h1,
        BOR_MODE_NOSLP  = 2'h2,
        BOR_MODE_ALWAYS = 2'h3
    } bor_mode_t;

    // Boot configuration word as seen by this block
    typedef struct packed {
        logic [1:0] threshold_select;
        bor_mode_t brownout_mode;
        logic powerup_delay_timer_en;
    } bor_cfg_t;

    // Analog side inputs
    typedef struct packed {
        logic below_threshold;
        logic reference_stable_flag;
        logic reference_other_user;
    } bor_ana_t;

    localparam int unsigned BOR_CLK_MHZ = 200;
    // Filter time in ns and power-up delay in us; the filter is fixed, the delay is only a default
    localparam int unsigned BOR_FILTER_NS = 200;
    localparam int unsigned BOR_POWERUP_DELAY_TIMER_US = 66;
    localparam int unsigned BOR_FILTER_CYC = (BOR_FILTER_NS * BOR_CLK_MHZ) / 1000;
    localparam int unsigned BOR_POWERUP_DELAY_TIMER_CYC = BOR_POWERUP_DELAY_TIMER_US * BOR_CLK_MHZ;

    // ************************************************************
    // Register map
    // ************************************************************

    localparam logic [7:0] BOR_ADDR_CTRL = 8'h00;
    localparam logic [7:0] BOR_ADDR_STAT = 8'h04;
    localparam logic [7:0] BOR_ADDR_FLAG = 8'h08;
    localparam logic [7:0] BOR_ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] BOR_ADDR_IRQ_MASK = 8'h10;

    localparam int unsigned BOR_BIT_SWEN = 0;
    localparam int unsigned BOR_BIT_POR_N = 0;
    localparam int unsigned BOR_BIT_BOR_N = 1;
    localparam int unsigned BOR_BIT_REF_OK = 0;
    localparam int unsigned BOR_BIT_DET_ON = 1;
    localparam int unsigned BOR_BIT_IN_RST = 2;
    localparam int unsigned BOR_IRQ_W = 2;
    localparam int unsigned BOR_IRQ_BOR = 0;
    localparam int unsigned BOR_IRQ_REL = 1;

endpackage : bor_pkg

// *** core/bor_ctrl.sv ***
// Behaviour
// [R1] Enabled mode: qualified dip beyond filter resets
// [R2] Reset held while supply below threshold; the code releases it once detection is disabled or the reference drops
// [R3] Optional power-up delay after recovery
// [R4] Dip during delay restarts brown-out and timer
// [R5] Delay timer enable independent of brown-out
// [R6] Detector output rearms power-on reset
// [R7] Brown-out flag cleared on brown-out/power-on; the code clears it on power-on only while detection is enabled
// [R8] Software sets both flags after power-on
// [R9] Mode 01: software bit enables detection
// [R10] Other modes ignore software bit, read 0
// [R11] Threshold only from config field
// [R12] Mode 10: detection off in Sleep
// [R13] Enable requests reference; active once stable; the code does not request it while reference_other_user is set
// [R14] No sensing before reference stable; status bit
// [R15] Mode 11: always enabled, even in Sleep
`timescale 1ns/1ps
`default_nettype none
module bor_ctrl
    import bor_pkg::*;
#(
    parameter int unsigned POWERUP_DELAY_TIMER_CYC = BOR_POWERUP_DELAY_TIMER_CYC
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire bor_cfg_t I_CFG,
    input wire bor_ana_t I_ANA,
    input wire logic I_POR_EVENT,
    input wire logic I_SLEEP,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_THRESHOLD_SELECT,
    output logic O_DETECTOR_EN,
    output logic O_REFERENCE_REQ,
    output logic O_POR_REARM,
    output logic O_RESET,
    output logic O_IRQ
);

    // ************************************************************
    // State
    // ************************************************************

    typedef enum logic [2:0] {
        ST_RUN   = 3'h1,
        ST_BROWN = 3'h2,
        ST_DELAY = 3'h4
    } bor_state_t;

    bor_state_t state;
    bor_state_t next_state;
    logic sw_brownout_enable;
    logic por_flag_n;
    logic brownout_flag_n;
    logic [BOR_IRQ_W-1:0] irq_stat;
    logic [BOR_IRQ_W-1:0] irq_mask;
    logic [15:0] filt_cnt;
    logic [31:0] powerup_delay_timer_cnt;
    logic want_en;
    logic sense;
    logic dip_ok;
    logic bor_event;
    logic wr_ctrl;
    logic wr_flag;
    logic wr_irq;

    // ************************************************************
    // Enable decode
    // ************************************************************

    // Mode chooses who owns the enable; threshold never comes from software
    always_comb begin
        case (I_CFG.brownout_mode)
            BOR_MODE_SW: want_en = sw_brownout_enable; // see [R9]
            BOR_MODE_NOSLP: want_en = !I_SLEEP; // see [R12]
            BOR_MODE_ALWAYS: want_en = 1'b1; // see [R15]
            default: want_en = 1'b0; // see [R1]
        endcase
    end

    // Sensing only once the reference reports stable
    assign sense = want_en && I_ANA.reference_stable_flag; // see [R13] see [R14]
    assign dip_ok = sense && I_ANA.below_threshold;
    assign bor_event = (state == ST_RUN) && dip_ok && (filt_cnt >= 16'(BOR_FILTER_CYC));
    assign wr_ctrl = I_WR && (I_ADDR == BOR_ADDR_CTRL);
    assign wr_flag = I_WR && (I_ADDR == BOR_ADDR_FLAG);
    assign wr_irq = I_WR && (I_ADDR == BOR_ADDR_IRQ_STAT);

    // Filter counter; a dip shorter than the filter time is forgotten
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            filt_cnt <= 16'h0;
        end else if (!dip_ok) begin
            filt_cnt <= 16'h0;
        end else if (filt_cnt <= 16'(BOR_FILTER_CYC)) begin
            filt_cnt <= filt_cnt + 16'h1; // see [R1]
        end
    end

    // ************************************************************
    // Reset sequencer
    // ************************************************************

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: if (bor_event) next_state = ST_BROWN;
            ST_BROWN: begin
                // Held while below; disabling detection also lets go
                if (!dip_ok) begin // see [R2]
                    next_state = I_CFG.powerup_delay_timer_en ? ST_DELAY : ST_RUN; // see [R3] see [R5]
                end
            end
            ST_DELAY: begin
                if (dip_ok) begin
                    next_state = ST_BROWN; // see [R4]
                end else if (powerup_delay_timer_cnt >= POWERUP_DELAY_TIMER_CYC - 1) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Power-up delay counter, reinitialised whenever not delaying
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            powerup_delay_timer_cnt <= 32'h0;
        end else if (state != ST_DELAY || dip_ok) begin
            powerup_delay_timer_cnt <= 32'h0; // see [R4]
        end else begin
            powerup_delay_timer_cnt <= powerup_delay_timer_cnt + 32'h1; // see [R3]
        end
    end

    // ************************************************************
    // Software register state
    // ************************************************************

    // Software enable bit only exists in software mode
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sw_brownout_enable <= 1'b0;
        end else if (I_CFG.brownout_mode != BOR_MODE_SW) begin
            sw_brownout_enable <= 1'b0; // see [R10]
        end else if (wr_ctrl) begin
            sw_brownout_enable <= I_WDATA[BOR_BIT_SWEN];
        end
    end

    // Event clears beat a software set in the same cycle
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            por_flag_n <= 1'b0;
            brownout_flag_n <= 1'b0;
        end else begin
            if (I_POR_EVENT) begin
                por_flag_n <= 1'b0;
            end else if (wr_flag && I_WDATA[BOR_BIT_POR_N]) begin
                por_flag_n <= 1'b1; // see [R8]
            end
            if ((bor_event || I_POR_EVENT) && want_en) begin
                brownout_flag_n <= 1'b0; // see [R7]
            end else if (wr_flag && I_WDATA[BOR_BIT_BOR_N]) begin
                brownout_flag_n <= 1'b1; // see [R8]
            end
        end
    end

    // Sticky events: brown-out entry and reset release; set beats clear
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            irq_stat[BOR_IRQ_BOR] <= bor_event
                || (irq_stat[BOR_IRQ_BOR] && !(wr_irq && I_WDATA[BOR_IRQ_BOR]));
            irq_stat[BOR_IRQ_REL] <= (state != ST_RUN && next_state == ST_RUN)
                || (irq_stat[BOR_IRQ_REL] && !(wr_irq && I_WDATA[BOR_IRQ_REL]));
            if (I_WR && I_ADDR == BOR_ADDR_IRQ_MASK) begin
                irq_mask <= I_WDATA[BOR_IRQ_W-1:0];
            end
        end
    end

    // ************************************************************
    // Read port and outputs
    // ************************************************************

    // Unmapped addresses read zero
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RDATA <= 32'h0;
        end else if (!I_RD) begin
            O_RDATA <= 32'h0;
        end else if (I_ADDR == BOR_ADDR_CTRL) begin
            O_RDATA <= {31'h0, sw_brownout_enable}; // see [R10]
        end else if (I_ADDR == BOR_ADDR_STAT) begin
            O_RDATA <= {29'h0, state != ST_RUN, sense, I_ANA.reference_stable_flag}; // see [R14]
        end else if (I_ADDR == BOR_ADDR_FLAG) begin
            O_RDATA <= {30'h0, brownout_flag_n, por_flag_n};
        end else if (I_ADDR == BOR_ADDR_IRQ_STAT) begin
            O_RDATA <= {30'h0, irq_stat};
        end else if (I_ADDR == BOR_ADDR_IRQ_MASK) begin
            O_RDATA <= {30'h0, irq_mask};
        end else begin
            O_RDATA <= 32'h0;
        end
    end

    // Registered outputs toward the analog side and core reset
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_THRESHOLD_SELECT <= 2'h0;
            O_DETECTOR_EN <= 1'b0;
            O_REFERENCE_REQ <= 1'b0;
            O_POR_REARM <= 1'b0;
            O_RESET <= 1'b1;
            O_IRQ <= 1'b0;
        end else begin
            O_THRESHOLD_SELECT <= I_CFG.threshold_select; // see [R11]
            O_DETECTOR_EN <= want_en;
            O_REFERENCE_REQ <= want_en && !I_ANA.reference_other_user; // see [R13]
            O_POR_REARM <= dip_ok; // see [R6]
            O_RESET <= (next_state != ST_RUN); // see [R2]
            O_IRQ <= |(irq_stat & irq_mask);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    a_reset_held: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        (state == ST_BROWN && dip_ok) |=> O_RESET) // see [R2]
        else $error("reset released while below threshold");
    a_swen_reads_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        (I_CFG.brownout_mode != BOR_MODE_SW) |=> !sw_brownout_enable) // see [R10]
        else $error("sw enable set outside software mode");
    a_no_sense_unstable: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        !I_ANA.reference_stable_flag |-> !bor_event) // see [R14]
        else $error("brown-out sensed before reference stable");
    a_dip_restarts: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        (state == ST_DELAY && dip_ok) |=> (state == ST_BROWN && powerup_delay_timer_cnt == 32'h0)) // see [R4]
        else $error("dip during delay did not restart");
    a_off_no_event: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        (I_CFG.brownout_mode == BOR_MODE_OFF) |-> !bor_event) // see [R1]
        else $error("brown-out in off mode");
    a_sleep_disables: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        (I_CFG.brownout_mode == BOR_MODE_NOSLP && I_SLEEP) |=> !O_DETECTOR_EN) // see [R12]
        else $error("detector on in sleep");
    a_always_on: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        (I_CFG.brownout_mode == BOR_MODE_ALWAYS) |=> O_DETECTOR_EN) // see [R15]
        else $error("detector off in always mode");
    a_flag_cleared: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        bor_event |=> !brownout_flag_n) // see [R7]
        else $error("brown-out flag not cleared");
    a_no_delay_skip: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        (state == ST_BROWN && !dip_ok && !I_CFG.powerup_delay_timer_en) |=> state == ST_RUN) // see [R5]
        else $error("delay used while disabled");

endmodule : bor_ctrl
`default_nettype wire

// *** tb/bor_ana_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Analog side: comparator and reference
// ****
module bor_ana_model
    import bor_pkg::*;
#(
    parameter int unsigned SETTLE = 8
) (
    input wire logic i_clk,
    input wire logic i_low,
    input wire logic i_other,
    input wire logic i_ref_req,
    output bor_ana_t o_ana
);
    logic [3:0] cnt = 4'h0;
    // Reference needs time to settle; it falls back at once when nobody wants it
    always @(posedge i_clk) begin
        if (!(i_ref_req || i_other)) cnt <= 4'h0;
        else if (cnt < 4'(SETTLE)) cnt <= cnt + 4'h1;
    end
    // Comparator level comes straight from the bench
    assign o_ana.below_threshold = i_low;
    assign o_ana.reference_stable_flag = (cnt >= 4'(SETTLE));
    assign o_ana.reference_other_user = i_other;
endmodule : bor_ana_model
`default_nettype wire

// *** tb/brownout_reset_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Self-checking bench
// ****
module brownout_reset_control_tb;
    import bor_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    bor_cfg_t cfg = '0;
    bor_ana_t ana;
    logic por = 1'b0, slp = 1'b0, wr = 1'b0, rd = 1'b0;
    logic low = 1'b0, oth = 1'b0, go = 1'b0, rd_q = 1'b0;
    logic [7:0] addr = 8'h0, lfsr = 8'h2c;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] ts;
    logic det, req, rearm, reset, irq;
    logic [31:0] notes[$];
    int failures = 0, samples_checked = 0;

    bor_ctrl #(.POWERUP_DELAY_TIMER_CYC(20)) bor_ctrl_inst (
        .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CFG(cfg), .I_ANA(ana),
        .I_POR_EVENT(por), .I_SLEEP(slp), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_THRESHOLD_SELECT(ts),
        .O_DETECTOR_EN(det), .O_REFERENCE_REQ(req), .O_POR_REARM(rearm),
        .O_RESET(reset), .O_IRQ(irq));
    bor_ana_model bor_ana_model_inst (
        .i_clk(clk), .i_low(low), .i_other(oth), .i_ref_req(req), .o_ana(ana));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Watcher: read data stands only in the cycle after the read; probes snapshot ports
    always @(posedge clk) begin
        if (rd_q) check(rdata, notes.pop_front());
        else if (go) check({25'h0, reset, irq, det, req, rearm, ts}, notes.pop_front());
        rd_q = rd;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic pe(input logic [4:0] v);
        @(posedge clk);
        go <= 1'b1;
        notes.push_back({25'h0, v, cfg.threshold_select});
        @(posedge clk);
        go <= 1'b0;
    endtask : pe
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        notes.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rdc
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    task automatic boot(input bor_mode_t m, input logic pw);
        @(posedge clk);
        rst_b <= 1'b0;
        lfsr = nxt(lfsr);
        cfg <= '{threshold_select: lfsr[1:0], brownout_mode: m, powerup_delay_timer_en: pw};
        cyc(20);
        rst_b <= 1'b1;
        cyc(14);
    endtask : boot
    // Long dip with a probe taken while the supply is still low
    task automatic dipc(input logic [4:0] v);
        low <= 1'b1;
        cyc(60);
        pe(v);
        low <= 1'b0;
    endtask : dipc

    // Watchdog sized well above the whole sequence
    initial begin
        #(40000 * 5);
        failures++;
        summarize();
    end

    // Main sequence
    initial begin
        boot(BOR_MODE_ALWAYS, 1'b1);
        rdc(BOR_ADDR_FLAG, 32'h0);
        wrr(BOR_ADDR_FLAG, 32'h3);
        rdc(BOR_ADDR_FLAG, 32'h3);
        pe(5'h06);
        lfsr = nxt(lfsr);
        low <= 1'b1;
        cyc(5 + int'(lfsr[4:0]));
        low <= 1'b0;
        pe(5'h06);
        rdc(BOR_ADDR_FLAG, 32'h3);
        dipc(5'h17);
        cyc(8);
        pe(5'h16);
        dipc(5'h17);
        cyc(12);
        pe(5'h16);
        cyc(20);
        pe(5'h06);
        rdc(BOR_ADDR_FLAG, 32'h1);
        rdc(BOR_ADDR_IRQ_STAT, 32'h3);
        wrr(BOR_ADDR_IRQ_MASK, 32'h1);
        pe(5'h0e);
        wrr(BOR_ADDR_IRQ_STAT, 32'h3);
        pe(5'h06);
        rdc(BOR_ADDR_IRQ_STAT, 32'h0);
        wrr(BOR_ADDR_FLAG, 32'h3);
        por <= 1'b1;
        cyc(1);
        por <= 1'b0;
        rdc(BOR_ADDR_FLAG, 32'h0);
        slp <= 1'b1;
        cyc(3);
        pe(5'h06);
        slp <= 1'b0;
        wrr(BOR_ADDR_CTRL, 32'h1);
        rdc(BOR_ADDR_CTRL, 32'h0);
        rdc(8'h14, 32'h0);
        $display("test always-on done");
        boot(BOR_MODE_NOSLP, 1'b0);
        slp <= 1'b1;
        cyc(3);
        dipc(5'h00);
        slp <= 1'b0;
        cyc(14);
        dipc(5'h17);
        cyc(3);
        pe(5'h06);
        oth <= 1'b1;
        cyc(3);
        pe(5'h04);
        oth <= 1'b0;
        $display("test no-sleep done");
        boot(BOR_MODE_SW, 1'b0);
        rdc(BOR_ADDR_CTRL, 32'h0);
        dipc(5'h00);
        wrr(BOR_ADDR_CTRL, 32'h1);
        rdc(BOR_ADDR_STAT, 32'h0);
        rdc(BOR_ADDR_CTRL, 32'h1);
        cyc(14);
        pe(5'h06);
        rdc(BOR_ADDR_STAT, 32'h3);
        wrr(BOR_ADDR_CTRL, 32'h0);
        cyc(2);
        wrr(BOR_ADDR_CTRL, 32'h1);
        low <= 1'b1;
        wrr(BOR_ADDR_CTRL, 32'h0);
        dipc(5'h00);
        $display("test software done");
        boot(BOR_MODE_OFF, 1'b1);
        dipc(5'h00);
        $display("test off done");
        summarize();
    end
endmodule : brownout_reset_control_tb
`default_nettype wire
